/* File: tone_output_control_filter.sv */
// Tone output stage: control generator, tone filter, level adjustment, DTMF path
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tone_output_control_filter #(
   parameter int SAMPLE_DIV = tone_output_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   // Register port
   input  wire logic [3:0]                  regAddr,
   input  wire logic [7:0]                  regWrData,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [7:0]                  regRdData,
   // Generator samples
   input  wire tone_output_pkg::gen_in_t    genIn,
   // Voice path samples
   output tone_output_pkg::voice_out_t      voiceOut,
   // Loudspeaker direct drive
   output logic                             lspkDrive,
   output logic                             lspkEnable,
   // Permissions back to the generators
   output logic                             dualAddAllow,
   output logic                             threeToneAllow
);

   // Software registers
   logic [7:0]  configReg_r;
   logic [7:0]  switchReg_r;
   logic [15:0] onPeriod_r;
   logic [15:0] offPeriod_r;
   logic [7:0]  centreFreq_r;
   logic [7:0]  bandwidth_r;
   logic [7:0]  stopBand_r;
   logic [7:0]  satGain_r;
   logic [7:0]  txGain_r;
   logic [7:0]  rxGain_r;
   logic [7:0]  thirdGain_r;
   logic [7:0]  dualGain_r;

   // Register writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         configReg_r  <= tone_output_pkg::CONFIG_RST;
         switchReg_r  <= tone_output_pkg::SWITCH_RST;
         onPeriod_r   <= tone_output_pkg::PERIOD_RST;
         offPeriod_r  <= tone_output_pkg::PERIOD_RST;
         centreFreq_r <= tone_output_pkg::COEF_RST;
         bandwidth_r  <= tone_output_pkg::COEF_RST;
         stopBand_r   <= tone_output_pkg::COEF_RST;
         satGain_r    <= tone_output_pkg::SAT_GAIN_RST;
         txGain_r     <= tone_output_pkg::LEVEL_RST;
         rxGain_r     <= tone_output_pkg::LEVEL_RST;
         thirdGain_r  <= tone_output_pkg::LEVEL_RST;
         dualGain_r   <= tone_output_pkg::LEVEL_RST;
      end else if (regWr) begin
         case (regAddr)
            tone_output_pkg::TONE_CONFIG_REG_OFS: configReg_r <= regWrData;
            tone_output_pkg::TONE_SWITCH_REG_OFS: switchReg_r <= regWrData;
            tone_output_pkg::ON_PERIOD_LO_OFS:    onPeriod_r[7:0] <= regWrData;
            tone_output_pkg::ON_PERIOD_HI_OFS:    onPeriod_r[15:8] <= regWrData;
            tone_output_pkg::OFF_PERIOD_LO_OFS:   offPeriod_r[7:0] <= regWrData;
            tone_output_pkg::OFF_PERIOD_HI_OFS:   offPeriod_r[15:8] <= regWrData;
            tone_output_pkg::CENTRE_FREQ_OFS:     centreFreq_r <= regWrData;
            tone_output_pkg::BANDWIDTH_OFS:       bandwidth_r <= regWrData;
            tone_output_pkg::STOPBAND_OFS:        stopBand_r <= regWrData;
            tone_output_pkg::SAT_GAIN_OFS:        satGain_r <= regWrData;
            tone_output_pkg::TX_GAIN_OFS:         txGain_r <= regWrData;
            tone_output_pkg::RX_GAIN_OFS:         rxGain_r <= regWrData;
            tone_output_pkg::THIRD_GAIN_OFS:      thirdGain_r <= regWrData;
            tone_output_pkg::DUAL_GAIN_OFS:       dualGain_r <= regWrData;
            default: ;
         endcase
      end
   end

   // Decoded control bits
   logic autoStop;
   logic waveSel;
   logic filterEn;
   logic toneEn;
   logic pulsed;
   logic lspkDirect;
   logic toTx;
   logic toRx;
   logic dtmfMode;
   assign autoStop   = configReg_r[tone_output_pkg::CFG_AUTO_STOP];
   assign waveSel    = configReg_r[tone_output_pkg::CFG_WAVE_SEL];
   assign filterEn   = configReg_r[tone_output_pkg::CFG_FILTER_EN];
   assign toneEn     = switchReg_r[tone_output_pkg::SW_TONE_EN];
   assign pulsed     = switchReg_r[tone_output_pkg::SW_PULSED];
   assign lspkDirect = switchReg_r[tone_output_pkg::SW_LSPK_DIRECT];
   assign toTx       = switchReg_r[tone_output_pkg::SW_TO_TX];
   assign toRx       = switchReg_r[tone_output_pkg::SW_TO_RX];
   assign dtmfMode   = switchReg_r[tone_output_pkg::SW_DTMF];

   // Sample tick divider
   logic [$clog2(SAMPLE_DIV)-1:0] divCnt_r;
   logic                          tick_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         divCnt_r <= '0;
         tick_r   <= 1'b0;
      end else if (divCnt_r == ($clog2(SAMPLE_DIV))'(SAMPLE_DIV - 1)) begin
         divCnt_r <= '0;
         tick_r   <= 1'b1;
      end else begin
         divCnt_r <= divCnt_r + 1'b1;
         tick_r   <= 1'b0;
      end
   end

   // Control generator state
   tone_output_pkg::gate_state_t gate_r;
   tone_output_pkg::gate_state_t gate_nxt;
   logic [7:0]  unitCnt_r;
   logic [15:0] periodCnt_r;
   logic        periodDone;
   logic        periodLoad;
   assign periodDone = tick_r && (unitCnt_r == 8'(tone_output_pkg::UNIT_TICKS - 1))
                       && (periodCnt_r <= 16'h0001);
   assign periodLoad = (gate_nxt != gate_r);

   // Next state of the control generator
   always_comb begin
      gate_nxt = gate_r;
      case (gate_r)
         tone_output_pkg::GATE_IDLE: begin
            if (pulsed) gate_nxt = tone_output_pkg::GATE_ON;
            else if (toneEn) gate_nxt = tone_output_pkg::GATE_CONT;
         end
         tone_output_pkg::GATE_CONT: begin
            if (pulsed) gate_nxt = tone_output_pkg::GATE_ON;
            else if (!toneEn) gate_nxt = autoStop ? tone_output_pkg::GATE_DRAIN
                                                  : tone_output_pkg::GATE_IDLE;
         end
         tone_output_pkg::GATE_ON: begin
            if (!pulsed) begin
               if (toneEn) gate_nxt = tone_output_pkg::GATE_CONT;
               else gate_nxt = autoStop ? tone_output_pkg::GATE_DRAIN
                                        : tone_output_pkg::GATE_IDLE;
            end else if (periodDone) begin
               gate_nxt = tone_output_pkg::GATE_OFF;
            end
         end
         tone_output_pkg::GATE_OFF: begin
            if (!pulsed) gate_nxt = toneEn ? tone_output_pkg::GATE_CONT
                                           : tone_output_pkg::GATE_IDLE;
            else if (periodDone) gate_nxt = tone_output_pkg::GATE_ON;
         end
         tone_output_pkg::GATE_DRAIN: begin
            if (pulsed) gate_nxt = tone_output_pkg::GATE_ON;
            else if (toneEn) gate_nxt = tone_output_pkg::GATE_CONT;
            else if (genIn.seqEnd || !autoStop) gate_nxt = tone_output_pkg::GATE_IDLE;
         end
         default: gate_nxt = tone_output_pkg::GATE_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) gate_r <= tone_output_pkg::GATE_IDLE;
      else     gate_r <= gate_nxt;
   end

   // On and off period counters in 20 ms units of sample ticks
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         unitCnt_r   <= '0;
         periodCnt_r <= tone_output_pkg::PERIOD_RST;
      end else if (periodLoad) begin
         unitCnt_r   <= '0;
         periodCnt_r <= (gate_nxt == tone_output_pkg::GATE_OFF) ? offPeriod_r : onPeriod_r;
      end else if (tick_r) begin
         if (unitCnt_r == 8'(tone_output_pkg::UNIT_TICKS - 1)) begin
            unitCnt_r <= '0;
            if (periodCnt_r > 16'h0001) periodCnt_r <= periodCnt_r - 1'b1;
         end else begin
            unitCnt_r <= unitCnt_r + 1'b1;
         end
      end
   end

   // Gate open while the tone is to be heard
   logic gateOpen;
   assign gateOpen = (gate_r == tone_output_pkg::GATE_CONT) || (gate_r == tone_output_pkg::GATE_ON)
                     || (gate_r == tone_output_pkg::GATE_DRAIN);

   // Waveform choice and gating
   logic signed [15:0] toneRaw;
   logic signed [15:0] toneGated;
   assign toneRaw   = waveSel ? genIn.seqSquare : genIn.seqTrap;
   assign toneGated = gateOpen ? toneRaw : 16'sh0000;

   // Scale a sample by an unsigned byte gain, 0 mutes, ff is near 0 dB
   function automatic logic signed [15:0] scale(input logic signed [15:0] x,
                                                input logic [7:0] g);
      logic signed [24:0] p;
      p = x * $signed({1'b0, g});
      return p[23:8];
   endfunction : scale

   // Equalizer: stop-band scale, resonator with centre and bandwidth coefficients
   logic signed [17:0] eqX1_r, eqX2_r, eqY1_r, eqY2_r;
   logic signed [17:0] eqIn;
   logic signed [25:0] eqFb1;
   logic signed [26:0] eqFb2;
   logic signed [19:0] eqSum;
   logic signed [17:0] eqOut;
   always_comb begin
      eqIn  = 18'(scale(toneGated, ~stopBand_r));
      eqFb1 = eqY1_r * $signed(centreFreq_r);
      eqFb2 = eqY2_r * $signed({1'b0, bandwidth_r});
      eqSum = 20'(eqIn) - 20'(eqX2_r) + 20'(eqFb1 >>> 6) - 20'(eqFb2 >>> 8);
      if (eqSum > 20'sh1ffff)       eqOut = 18'sh1ffff;
      else if (eqSum < -20'sh1ffff) eqOut = -18'sh1ffff;
      else                          eqOut = eqSum[17:0];
   end

   // Equalizer history, advanced once per sample
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eqX1_r <= '0;
         eqX2_r <= '0;
         eqY1_r <= '0;
         eqY2_r <= '0;
      end else if (tick_r && filterEn) begin
         eqX1_r <= eqIn;
         eqX2_r <= eqX1_r;
         eqY1_r <= eqOut;
         eqY2_r <= eqY1_r;
      end
   end

   // Saturation amplifier, gain byte in sixty-fourths from zero to almost four times, clipped to full scale
   logic signed [26:0] satProd;
   logic signed [15:0] satOut;
   logic signed [15:0] filtered;
   always_comb begin
      satProd = eqOut * $signed({1'b0, satGain_r});
      if ((satProd >>> 6) > 27'(tone_output_pkg::SMP_MAX))      satOut = tone_output_pkg::SMP_MAX;
      else if ((satProd >>> 6) < 27'(tone_output_pkg::SMP_MIN)) satOut = tone_output_pkg::SMP_MIN;
      else                                                       satOut = satProd[21:6];
      filtered = filterEn ? satOut : toneGated;
   end

   // DTMF sum of third and dual generators, each with its own gain
   logic signed [16:0] dtmfSum;
   logic signed [15:0] dtmfTone;
   always_comb begin
      dtmfSum = 17'(scale(genIn.thirdTrap, thirdGain_r)) + 17'(scale(genIn.dualTrap, dualGain_r));
      if (dtmfSum > 17'(tone_output_pkg::SMP_MAX))      dtmfTone = tone_output_pkg::SMP_MAX;
      else if (dtmfSum < 17'(tone_output_pkg::SMP_MIN)) dtmfTone = tone_output_pkg::SMP_MIN;
      else                                               dtmfTone = dtmfSum[15:0];
   end

   // Transmit low-pass used in DTMF mode, one pole per sample
   logic signed [17:0] lpY_r;
   logic signed [17:0] lpNext;
   logic signed [15:0] txSource;
   assign txSource = dtmfMode ? (gateOpen ? dtmfTone : 16'sh0000) : filtered;
   assign lpNext   = lpY_r + ((18'(txSource) - lpY_r) >>> 2);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)                      lpY_r <= '0;
      else if (tick_r && dtmfMode)  lpY_r <= lpNext;
      else if (tick_r)              lpY_r <= '0;
   end

   // Voice path outputs, one new sample per tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         voiceOut <= '0;
      end else begin
         voiceOut.sampleValid <= tick_r;
         if (tick_r) begin
            voiceOut.txInsert <= toTx || dtmfMode;
            voiceOut.rxInsert <= toRx && !dtmfMode;
            voiceOut.txSample <= (toTx || dtmfMode)
                                 ? scale(dtmfMode ? lpNext[15:0] : txSource, txGain_r)
                                 : 16'sh0000;
            voiceOut.rxSample <= (toRx && !dtmfMode) ? scale(filtered, rxGain_r)
                                                     : 16'sh0000;
         end
      end
   end

   // Loudspeaker direct drive: square wave at full supply swing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lspkDrive  <= 1'b0;
         lspkEnable <= 1'b0;
      end else begin
         lspkEnable <= lspkDirect;
         lspkDrive  <= lspkDirect && gateOpen && genIn.squareLevel;
      end
   end

   // Generator permissions outside DTMF mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dualAddAllow   <= 1'b1;
         threeToneAllow <= 1'b1;
      end else begin
         dualAddAllow   <= !dtmfMode;
         threeToneAllow <= !dtmfMode;
      end
   end

   // Read data, valid in the cycle after the strobe only
   logic [7:0] rdMux;
   always_comb begin
      case (regAddr)
         tone_output_pkg::TONE_CONFIG_REG_OFS: rdMux = configReg_r;
         tone_output_pkg::TONE_SWITCH_REG_OFS: rdMux = switchReg_r;
         tone_output_pkg::ON_PERIOD_LO_OFS:    rdMux = onPeriod_r[7:0];
         tone_output_pkg::ON_PERIOD_HI_OFS:    rdMux = onPeriod_r[15:8];
         tone_output_pkg::OFF_PERIOD_LO_OFS:   rdMux = offPeriod_r[7:0];
         tone_output_pkg::OFF_PERIOD_HI_OFS:   rdMux = offPeriod_r[15:8];
         tone_output_pkg::CENTRE_FREQ_OFS:     rdMux = centreFreq_r;
         tone_output_pkg::BANDWIDTH_OFS:       rdMux = bandwidth_r;
         tone_output_pkg::STOPBAND_OFS:        rdMux = stopBand_r;
         tone_output_pkg::SAT_GAIN_OFS:        rdMux = satGain_r;
         tone_output_pkg::TX_GAIN_OFS:         rdMux = txGain_r;
         tone_output_pkg::RX_GAIN_OFS:         rdMux = rxGain_r;
         tone_output_pkg::THIRD_GAIN_OFS:      rdMux = thirdGain_r;
         tone_output_pkg::DUAL_GAIN_OFS:       rdMux = dualGain_r;
         tone_output_pkg::STATUS_OFS:          rdMux = {4'h0, gateOpen, gate_r};
         default:                              rdMux = 8'h00;
      endcase
   end

   // Read data register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)        regRdData <= 8'h00;
      else if (regRd) regRdData <= rdMux;
      else            regRdData <= 8'h00;
   end

endmodule : tone_output_control_filter

/* File: tone_output_pkg.sv */
// Constants, register map and carrier types of the tone output stage
package tone_output_pkg;

   // Register port geometry and sample width
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int SMP_W  = 16;

   // Register offsets
   localparam logic [3:0] TONE_CONFIG_REG_OFS = 4'h0;
   localparam logic [3:0] TONE_SWITCH_REG_OFS = 4'h1;
   localparam logic [3:0] ON_PERIOD_LO_OFS    = 4'h2;
   localparam logic [3:0] ON_PERIOD_HI_OFS    = 4'h3;
   localparam logic [3:0] OFF_PERIOD_LO_OFS   = 4'h4;
   localparam logic [3:0] OFF_PERIOD_HI_OFS   = 4'h5;
   localparam logic [3:0] CENTRE_FREQ_OFS     = 4'h6;
   localparam logic [3:0] BANDWIDTH_OFS       = 4'h7;
   localparam logic [3:0] STOPBAND_OFS        = 4'h8;
   localparam logic [3:0] SAT_GAIN_OFS        = 4'h9;
   localparam logic [3:0] TX_GAIN_OFS         = 4'ha;
   localparam logic [3:0] RX_GAIN_OFS         = 4'hb;
   localparam logic [3:0] THIRD_GAIN_OFS      = 4'hc;
   localparam logic [3:0] DUAL_GAIN_OFS       = 4'hd;
   localparam logic [3:0] STATUS_OFS          = 4'he;

   // Field positions in tone_config_reg
   localparam int CFG_AUTO_STOP  = 0;
   localparam int CFG_WAVE_SEL   = 1;
   localparam int CFG_FILTER_EN  = 2;
   // Field positions in tone_switch_reg
   localparam int SW_TONE_EN     = 0;
   localparam int SW_PULSED      = 1;
   localparam int SW_LSPK_DIRECT = 2;
   localparam int SW_TO_TX       = 3;
   localparam int SW_TO_RX       = 4;
   localparam int SW_DTMF        = 5;

   // Values after reset
   localparam logic [7:0]  CONFIG_RST    = 8'h00;
   localparam logic [7:0]  SWITCH_RST    = 8'h00;
   localparam logic [15:0] PERIOD_RST    = 16'h0001;
   localparam logic [7:0]  COEF_RST      = 8'h00;
   localparam logic [7:0]  SAT_GAIN_RST  = 8'h40;
   localparam logic [7:0]  LEVEL_RST     = 8'hff;

   // Timing: sample rate and period unit
   localparam int CLK_HZ        = 200_000_000;
   localparam int SAMPLE_HZ     = 8_000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int PERIOD_UNIT_MS = 20;
   localparam int UNIT_TICKS    = PERIOD_UNIT_MS * SAMPLE_HZ / 1000;

   // Full-scale sample level (maximum PCM level)
   localparam logic signed [SMP_W-1:0] SMP_MAX = 16'sh7fff;
   localparam logic signed [SMP_W-1:0] SMP_MIN = -16'sh7fff;

   // Control generator states, Gray along the usual path
   typedef enum logic [2:0] {
      GATE_IDLE  = 3'b000,
      GATE_CONT  = 3'b001,
      GATE_ON    = 3'b011,
      GATE_OFF   = 3'b010,
      GATE_DRAIN = 3'b110
   } gate_state_t;

   // Samples from the signal and sequence generators
   typedef struct packed {
      logic signed [SMP_W-1:0] seqTrap;
      logic signed [SMP_W-1:0] seqSquare;
      logic                    squareLevel;
      logic                    seqEnd;
      logic signed [SMP_W-1:0] thirdTrap;
      logic signed [SMP_W-1:0] dualTrap;
   } gen_in_t;

   // Samples toward the voice paths
   typedef struct packed {
      logic signed [SMP_W-1:0] txSample;
      logic                    txInsert;
      logic signed [SMP_W-1:0] rxSample;
      logic                    rxInsert;
      logic                    sampleValid;
   } voice_out_t;

endpackage : tone_output_pkg

/* File: tone_output_control_filter_asserts.sv */
// Port-level checks of the tone output stage
`timescale 1ns/1ps
module tone_output_control_filter_asserts #(
   parameter int SAMPLE_DIV = 20
) (
   // Clock and reset
   input wire logic                        ref_clk,
   input wire logic                        rst,
   // Register port
   input wire logic                        regRd,
   input wire logic [7:0]                  regRdData,
   // Samples and permissions
   input wire tone_output_pkg::voice_out_t voiceOut,
   input wire logic                        dualAddAllow,
   input wire logic                        threeToneAllow
);
   logic [15:0] gap_r;
   logic        seen_r;

   // Cycles since the last sample strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gap_r  <= 16'h0000;
         seen_r <= 1'b0;
      end else if (voiceOut.sampleValid) begin
         gap_r  <= 16'h0000;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 16'h0001;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_valid_one_cycle: assert property (
      voiceOut.sampleValid |=> !voiceOut.sampleValid) else $error("strobe too long");
   a_valid_spacing: assert property (
      voiceOut.sampleValid && seen_r |-> gap_r == 16'(SAMPLE_DIV - 1))
      else $error("sample spacing wrong");
   a_tx_hold: assert property (
      !voiceOut.sampleValid |-> $stable(voiceOut.txSample) && $stable(voiceOut.txInsert))
      else $error("tx sample moved between ticks");
   a_rx_hold: assert property (
      !voiceOut.sampleValid |-> $stable(voiceOut.rxSample) && $stable(voiceOut.rxInsert))
      else $error("rx sample moved between ticks");
   a_allow_pair: assert property (
      dualAddAllow == threeToneAllow) else $error("permissions disagree");
   a_dtmf_no_rx: assert property (
      voiceOut.sampleValid && !dualAddAllow |-> !voiceOut.rxInsert)
      else $error("receive insert in dual-tone dialling");
   a_clip_tx: assert property (
      voiceOut.txSample != 16'h8000) else $error("tx sample beyond clip");
   a_clip_rx: assert property (
      voiceOut.rxSample != 16'h8000) else $error("rx sample beyond clip");
   a_read_idle: assert property (
      !$past(regRd) |-> regRdData == 8'h00) else $error("read data outside its cycle");
endmodule : tone_output_control_filter_asserts

bind tone_output_control_filter tone_output_control_filter_asserts #(
   .SAMPLE_DIV(SAMPLE_DIV)
) tone_output_control_filter_asserts_i (.ref_clk, .rst, .regRd, .regRdData, .voiceOut,
   .dualAddAllow, .threeToneAllow);

/* File: tone_gen_model.sv */
// Behavioural source of generator samples for the tone output stage
`timescale 1ns/1ps
module tone_gen_model (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst,
   // Bench request for end of sequence
   input  wire logic                endReq,
   // Samples toward the stage
   output tone_output_pkg::gen_in_t genIn
);
   logic [3:0] phase_r;
   logic       seqEnd_r;

   // Square polarity and one-cycle end-of-sequence pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase_r  <= 4'h0;
         seqEnd_r <= 1'b0;
      end else begin
         phase_r  <= phase_r + 4'h1;
         seqEnd_r <= endReq;
      end
   end

   // Trapezoid and square forms at fixed levels, dialling pair at one equal fixed level
   assign genIn = '{16'sh0100, 16'sh0200, phase_r[3], seqEnd_r,
                    16'sh0100, 16'sh0100};
endmodule : tone_gen_model

/* File: test_tone_output_control_filter.sv */
// Self-checking bench for the tone output stage
`timescale 1ns/1ps
module test_tone_output_control_filter;
   localparam int         DIV = 20;
   localparam logic [3:0] CF  = tone_output_pkg::TONE_CONFIG_REG_OFS;
   localparam logic [3:0] SW  = tone_output_pkg::TONE_SWITCH_REG_OFS;
   localparam logic [3:0] ST  = tone_output_pkg::STATUS_OFS;
   logic                        ref_clk;
   logic                        rst;
   logic [3:0]                  regAddr;
   logic [7:0]                  regWrData;
   logic                        regWr;
   logic                        regRd;
   logic [7:0]                  regRdData;
   logic                        endReq;
   tone_output_pkg::gen_in_t    genIn;
   tone_output_pkg::voice_out_t voiceOut;
   logic                        lspkDrive;
   logic                        lspkEnable;
   logic                        dualAddAllow;
   logic                        threeToneAllow;
   int                          mismatches;
   int                          comparisons;
   int                          cycles;
   logic [7:0]                  rdv;
   logic [15:0]                 txS;
   logic [15:0]                 rxS;
   logic [1:0]                  ins;
   logic [7:0] rstVal [0:15] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h40, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};

   tone_output_control_filter #(.SAMPLE_DIV(DIV)) tone_output_control_filter_i (.ref_clk, .rst,
      .regAddr, .regWrData, .regWr, .regRd, .regRdData, .genIn, .voiceOut, .lspkDrive,
      .lspkEnable, .dualAddAllow, .threeToneAllow);
   tone_gen_model tone_gen_model_i (.ref_clk, .rst, .endReq, .genIn);

   // Clock and hang limit
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         test_done;
      end
   end

   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [7:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge ref_clk);
      regWr     <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task rd(input logic [3:0] a, input logic [7:0] e, input bit c);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge ref_clk);
      regRd   <= 1'b0;
      #1;
      rdv = regRdData;
      if (c) chk("regRdData", {8'h00, e}, {8'h00, rdv});
      @(posedge ref_clk);
   endtask : rd

   // Waits for n sample strobes and captures the last one
   task tick(input int n);
      int k;
      k = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         while (voiceOut.sampleValid !== 1'b1 && k < 400 * n) begin
            @(posedge ref_clk);
            #1;
            k++;
         end
      end
      txS = voiceOut.txSample;
      rxS = voiceOut.rxSample;
      ins = {voiceOut.txInsert, voiceOut.rxInsert};
      @(posedge ref_clk);
   endtask : tick

   task t_reset;
      for (int a = 0; a < 16; a++) rd(4'(a), rstVal[a], 1'b1);
      wr(4'hf, 8'h5a);
      rd(4'hf, 8'h00, 1'b1);
      wr(ST, 8'hff);
      rd(ST, 8'h00, 1'b1);
      chk("allow", 16'h0001, {15'h0000, dualAddAllow});
   endtask : t_reset

   task t_levels;
      wr(SW, 8'h09);
      tick(2);
      chk("txCont", 16'h00ff, txS);
      chk("insCont", 16'h0002, {14'h0000, ins});
      rd(ST, 8'h09, 1'b1);
      wr(CF, 8'h02);
      tick(2);
      chk("txSquare", 16'h01fe, txS);
      wr(tone_output_pkg::TX_GAIN_OFS, 8'h00);
      tick(2);
      chk("txMute", 16'h0000, txS);
      wr(CF, 8'h00);
      wr(tone_output_pkg::RX_GAIN_OFS, 8'h80);
      wr(SW, 8'h11);
      tick(2);
      chk("rxHalf", 16'h0080, rxS);
      chk("insRx", 16'h0001, {14'h0000, ins});
      wr(tone_output_pkg::TX_GAIN_OFS, 8'hff);
      wr(SW, 8'h08);
      tick(2);
      chk("txSilent", 16'h0000, txS);
      rd(ST, 8'h00, 1'b1);
      wr(SW, 8'h05);
      #1;
      chk("lspk", 16'h0001, {15'h0000, lspkEnable});
      // Square drive must swing while the gate is open
      @(posedge ref_clk);
      #1;
      rdv[0] = lspkDrive;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("lspkSwing", 16'h0001, {15'h0000, lspkDrive !== rdv[0]});
      @(posedge ref_clk);
   endtask : t_levels

   task t_auto;
      wr(CF, 8'h01);
      wr(SW, 8'h09);
      tick(1);
      wr(SW, 8'h08);
      rd(ST, 8'h0e, 1'b1);
      tick(2);
      chk("txDrain", 16'h00ff, txS);
      endReq <= 1'b1;
      @(posedge ref_clk);
      endReq <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(ST, 8'h00, 1'b1);
      wr(CF, 8'h04);
      wr(SW, 8'h09);
      tick(20);
      chk("filtered", 16'h0000, txS);
      wr(CF, 8'h00);
      wr(SW, 8'h00);
      tick(20);
   endtask : t_auto

   task t_dtmf;
      wr(tone_output_pkg::THIRD_GAIN_OFS, 8'h80);
      wr(tone_output_pkg::DUAL_GAIN_OFS, 8'ha1);
      wr(SW, 8'h21);
      #1;
      chk("allowDtmf", 16'h0000, {14'h0000, dualAddAllow, threeToneAllow});
      tick(2);
      chk("lag", 16'h0001, {15'h0000, txS < 16'h0121});
      tick(40);
      chk("dtmfSum", 16'h0001, {15'h0000, txS > 16'h0110 && txS <= 16'h0121});
      chk("insDtmf", 16'h0002, {14'h0000, ins});
      wr(SW, 8'h00);
   endtask : t_dtmf

   task t_pulse;
      int on;
      int off;
      on  = 0;
      off = 0;
      wr(tone_output_pkg::OFF_PERIOD_LO_OFS, 8'h02);
      wr(SW, 8'h0a);
      rd(ST, 8'h0b, 1'b1);
      tick(1);
      chk("txOn", 16'h00ff, txS);
      do begin
         tick(1);
         rd(ST, 8'h00, 1'b0);
         on++;
      end while (rdv === 8'h0b && on < 400);
      do begin
         tick(1);
         off++;
         if (off == 5) chk("txOff", 16'h0000, txS);
         rd(ST, 8'h00, 1'b0);
      end while (rdv === 8'h02 && off < 700);
      chk("onTicks", 16'h0001, {15'h0000, on >= 159 && on <= 162});
      chk("offTicks", 16'h0001, {15'h0000, off >= 319 && off <= 322});
      chk("reopen", 16'h000b, {8'h00, rdv});
   endtask : t_pulse

   // Reset, then the scenarios in turn
   initial begin
      rst         = 1'b1;
      regAddr     = 4'h0;
      regWrData   = 8'h00;
      regWr       = 1'b0;
      regRd       = 1'b0;
      endReq      = 1'b0;
      mismatches  = 0;
      comparisons = 0;
      cycles      = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_reset;
      t_levels;
      t_auto;
      t_dtmf;
      t_pulse;
      test_done;
   end
endmodule : test_tone_output_control_filter
